// >>> design/ata_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module ata_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic flush_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic in_ready_q;
	logic out_valid_q;
	logic push;
	logic pop;
	// flags registered from the next count
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign in_ready_o = in_ready_q;
	assign out_valid_o = out_valid_q;
	assign out_data_o = mem[rd_q];
	assign push = in_valid_i & in_ready_q;
	assign pop = out_valid_q & out_ready_i;
	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem[wr_q] <= in_data_i;
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			in_ready_q <= 1'b1;
			out_valid_q <= 1'b0;
		end else if (flush_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			in_ready_q <= 1'b1;
			out_valid_q <= 1'b0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_d;
			in_ready_q <= (cnt_d != (AW+1)'(DEPTH));
			out_valid_q <= (cnt_d != '0);
		end
	end
endmodule

// >>> design/ata_hs_dev.sv
// storage target end of the ata handshake signals
// Functional notes
// - ready pin role follows transfer mode
// - negated ready stretches host strobe cycle (not done here: ready is held high in pio and the host has no pio strobe)
// - ready always asserted in pio
// - write-ready asserted when able to accept
// - write-ready negated pauses host data-out
// - every strobe edge carries one word
// - strobe stops toggling to pause burst
// - word indicator low on word access
// - interrupt request is active high
// - low host reset resets interface
// - host stop ends ultra dma burst
`timescale 1ns/1ps
module ata_hs_dev #(
	parameter int unsigned DEPTH = ata_hs_pkg::FIFO_DEPTH
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	ata_hs_if.dev bus,
	input wire logic [15:0] rd_data_i,
	input wire logic rd_valid_i,
	output logic rd_ready_o,
	output logic [15:0] wr_data_o,
	output logic wr_valid_o,
	input wire logic wr_ready_i,
	input wire logic word_access_i,
	input wire logic irq_req_i,
	input wire logic diag_pass_i,
	input wire logic active_i,
	output logic peer_diag_o,
	output logic peer_present_o
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_SEND = 3'h2,
		ST_HALT = 3'h4
	} st_t;
	st_t st_q;
	logic [1:0] rst_s_q, stop_s_q, ws_s_q, pd_s_q, da_s_q;
	logic [1:0] mode_s0_q, mode_s1_q;
	logic ws_prev_q;
	logic strobe_q, rs_q, word_q, intrq_q, pd_oe_q, da_oe_q, peer_diag_q, peer_pres_q;
	logic [7:0] half_q;
	logic [15:0] data_q;
	logic data_oe_q;
	logic rst_n;
	logic stop;
	logic [1:0] mode;
	logic wf_ready, wf_valid;
	logic [15:0] hd_s0_q, hd_s1_q;
	localparam int unsigned OW = $clog2(DEPTH) + 1;
	logic [OW-1:0] occ_q;
	logic wr_room;
	logic rf_valid, rf_ready;
	logic [15:0] rf_data;
	logic half_tick;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s_q <= 2'h0;
			stop_s_q <= 2'h0;
			ws_s_q <= 2'h3;
			pd_s_q <= 2'h3;
			da_s_q <= 2'h3;
			mode_s0_q <= ata_hs_pkg::MODE_IDLE;
			mode_s1_q <= ata_hs_pkg::MODE_IDLE;
			hd_s0_q <= 16'h0000;
			hd_s1_q <= 16'h0000;
		end else begin
			rst_s_q <= {rst_s_q[0], bus.reset_n};
			stop_s_q <= {stop_s_q[0], bus.stop};
			ws_s_q <= {ws_s_q[0], bus.host_wstrobe};
			pd_s_q <= {pd_s_q[0], bus.pdiag_n};
			da_s_q <= {da_s_q[0], bus.dasp_n};
			mode_s0_q <= bus.mode;
			mode_s1_q <= mode_s0_q;
			hd_s0_q <= bus.host_data;
			hd_s1_q <= hd_s0_q;
		end
	end
	assign rst_n = rst_s_q[1];
	assign stop = stop_s_q[1];
	assign mode = mode_s1_q;
	ata_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_wr_fifo (
		.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .flush_i(!rst_n),
		.in_data_i(hd_s1_q), .in_valid_i(wf_valid), .in_ready_o(wf_ready),
		.out_data_o(wr_data_o), .out_valid_o(wr_valid_o), .out_ready_i(wr_ready_i)
	);
	// host data-out word taken on each write-strobe edge
	assign wf_valid = (mode == ata_hs_pkg::MODE_UDMA_WR) && (ws_s_q[1] != ws_prev_q) && !stop;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			occ_q <= '0;
		end else if (!rst_n) begin
			occ_q <= '0;
		end else begin
			occ_q <= occ_q + OW'(wf_valid && wf_ready) - OW'(wr_valid_o && wr_ready_i);
		end
	end
	assign wr_room = (occ_q <= OW'(DEPTH - ata_hs_pkg::WR_SLACK));
	ata_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_rd_fifo (
		.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .flush_i(!rst_n),
		.in_data_i(rd_data_i), .in_valid_i(rd_valid_i), .in_ready_o(rd_ready_o),
		.out_data_o(rf_data), .out_valid_o(rf_valid), .out_ready_i(rf_ready)
	);
	assign half_tick = (half_q == 8'(ata_hs_pkg::STROBE_HALF_CYC - 1));
	// pop only when the word really goes out on a strobe edge
	assign rf_ready = (st_q == ST_SEND) && half_tick && data_oe_q && !stop && (mode == ata_hs_pkg::MODE_UDMA_RD);
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ws_prev_q <= 1'b1;
		end else begin
			ws_prev_q <= ws_s_q[1];
		end
	end
	// burst sequencer for data-in
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q <= ST_IDLE;
			half_q <= 8'h00;
			strobe_q <= 1'b1;
			data_q <= 16'h0000;
			data_oe_q <= 1'b0;
		end else if (!rst_n) begin
			st_q <= ST_IDLE;
			half_q <= 8'h00;
			strobe_q <= 1'b1;
			data_oe_q <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					half_q <= 8'h00;
					strobe_q <= 1'b1;
					if (mode == ata_hs_pkg::MODE_UDMA_RD && !stop) begin
						st_q <= ST_SEND;
						data_oe_q <= 1'b1;
					end
				end
				ST_SEND: begin
					if (stop || mode != ata_hs_pkg::MODE_UDMA_RD) begin
						st_q <= ST_HALT;
					end else if (half_tick) begin
						half_q <= 8'h00;
						if (rf_valid) begin
							data_q <= rf_data;
							strobe_q <= ~strobe_q;
						end
					end else begin
						half_q <= half_q + 8'h01;
					end
				end
				ST_HALT: begin
					// strobe held: a late edge would look like a word
					data_oe_q <= 1'b0;
					if (!stop && mode != ata_hs_pkg::MODE_UDMA_RD) begin
						st_q <= ST_IDLE;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rs_q <= 1'b1;
		end else begin
			case (mode)
				ata_hs_pkg::MODE_PIO: rs_q <= 1'b1;
				ata_hs_pkg::MODE_UDMA_WR: rs_q <= !(rst_n && wf_ready && wr_room && !stop);
				ata_hs_pkg::MODE_UDMA_RD: rs_q <= strobe_q;
				default: rs_q <= 1'b1;
			endcase
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			word_q <= 1'b1;
			intrq_q <= 1'b0;
		end else begin
			word_q <= !(rst_n && word_access_i);
			intrq_q <= rst_n && irq_req_i;
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pd_oe_q <= 1'b0;
			da_oe_q <= 1'b0;
			peer_diag_q <= 1'b0;
			peer_pres_q <= 1'b0;
		end else begin
			pd_oe_q <= rst_n && diag_pass_i;
			da_oe_q <= rst_n && active_i;
			peer_diag_q <= !pd_s_q[1];
			peer_pres_q <= !da_s_q[1];
		end
	end
	assign bus.ready_strobe = rs_q;
	assign bus.word_xfer_n = word_q;
	assign bus.intrq = intrq_q;
	assign bus.pdiag_dev_o = 1'b0;
	assign bus.pdiag_dev_oe = pd_oe_q;
	assign bus.dasp_dev_o = 1'b0;
	assign bus.dasp_dev_oe = da_oe_q;
	assign bus.dev_data = data_q;
	assign peer_diag_o = peer_diag_q;
	assign peer_present_o = peer_pres_q;
endmodule

// >>> design/ata_hs_host.sv
// host controller end of the ata handshake signals
`timescale 1ns/1ps
module ata_hs_host (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	ata_hs_if.host bus,
	input wire logic [1:0] mode_i,
	input wire logic dev_reset_i,
	input wire logic stop_i,
	input wire logic [15:0] wr_data_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	output logic [15:0] rd_data_o,
	output logic rd_valid_o,
	output logic io_ready_o,
	output logic word_xfer_o,
	output logic irq_o,
	output logic diag_pass_o,
	output logic dev_active_o
);
	logic [1:0] rs_s_q, w_s_q, i_s_q, p_s_q, d_s_q;
	logic rs_prev_q;
	logic ws_q, stop_q, rst_q, wr_ready_q, rd_valid_q, io_rdy_q, word_q, irq_q, diag_q, act_q;
	logic [1:0] mode_q;
	logic [15:0] wd_q, rd_q;
	logic [15:0] din_q;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rs_s_q <= 2'h3;
			w_s_q <= 2'h3;
			i_s_q <= 2'h0;
			p_s_q <= 2'h3;
			d_s_q <= 2'h3;
			rs_prev_q <= 1'b1;
			din_q <= 16'h0000;
		end else begin
			rs_s_q <= {rs_s_q[0], bus.ready_strobe};
			w_s_q <= {w_s_q[0], bus.word_xfer_n};
			i_s_q <= {i_s_q[0], bus.intrq};
			p_s_q <= {p_s_q[0], bus.pdiag_n};
			d_s_q <= {d_s_q[0], bus.dasp_n};
			rs_prev_q <= rs_s_q[1];
			din_q <= bus.dev_data;
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_q <= 1'b0;
			mode_q <= ata_hs_pkg::MODE_IDLE;
			stop_q <= 1'b0;
		end else begin
			rst_q <= !dev_reset_i;
			mode_q <= mode_i;
			stop_q <= stop_i;
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ws_q <= 1'b1;
			wd_q <= 16'h0000;
			wr_ready_q <= 1'b0;
		end else begin
			wr_ready_q <= 1'b0;
			if (mode_q == ata_hs_pkg::MODE_UDMA_WR && !rs_s_q[1] && !stop_q && wr_valid_i && !wr_ready_q) begin
				wd_q <= wr_data_i;
				ws_q <= ~ws_q;
				wr_ready_q <= 1'b1;
			end
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_q <= 16'h0000;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= (mode_q == ata_hs_pkg::MODE_UDMA_RD) && (rs_s_q[1] != rs_prev_q);
			rd_q <= din_q;
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			io_rdy_q <= 1'b0;
			word_q <= 1'b0;
			irq_q <= 1'b0;
			diag_q <= 1'b0;
			act_q <= 1'b0;
		end else begin
			io_rdy_q <= (mode_q == ata_hs_pkg::MODE_PIO) && rs_s_q[1];
			word_q <= !w_s_q[1];
			irq_q <= i_s_q[1];
			diag_q <= !p_s_q[1];
			act_q <= !d_s_q[1];
		end
	end
	assign bus.reset_n = rst_q;
	assign bus.mode = mode_q;
	assign bus.stop = stop_q;
	assign bus.host_wstrobe = ws_q;
	assign bus.host_data = wd_q;
	assign bus.pdiag_host_o = 1'b1;
	assign bus.pdiag_host_oe = 1'b0;
	assign bus.dasp_host_o = 1'b1;
	assign bus.dasp_host_oe = 1'b0;
	assign wr_ready_o = wr_ready_q;
	assign rd_data_o = rd_q;
	assign rd_valid_o = rd_valid_q;
	assign io_ready_o = io_rdy_q;
	assign word_xfer_o = word_q;
	assign irq_o = irq_q;
	assign diag_pass_o = diag_q;
	assign dev_active_o = act_q;
endmodule

// >>> design/ata_hs_if.sv
// wires between the storage target and its host controller
`timescale 1ns/1ps
interface ata_hs_if;
	logic ready_strobe;
	logic word_xfer_n;
	logic intrq;
	logic reset_n;
	logic stop;
	logic [15:0] host_data;
	logic [15:0] dev_data;
	logic pdiag_dev_o;
	logic pdiag_dev_oe;
	logic pdiag_host_o;
	logic pdiag_host_oe;
	logic dasp_dev_o;
	logic dasp_dev_oe;
	logic dasp_host_o;
	logic dasp_host_oe;
	logic host_wstrobe;
	logic [1:0] mode;
	logic pdiag_n;
	logic dasp_n;
	// open-drain resolution, low wins
	assign pdiag_n = ~((pdiag_dev_oe & ~pdiag_dev_o) | (pdiag_host_oe & ~pdiag_host_o));
	assign dasp_n = ~((dasp_dev_oe & ~dasp_dev_o) | (dasp_host_oe & ~dasp_host_o));
	modport dev(output ready_strobe, word_xfer_n, intrq, pdiag_dev_o, pdiag_dev_oe, dasp_dev_o, dasp_dev_oe,
		output dev_data, input reset_n, stop, host_wstrobe, mode, pdiag_n, dasp_n, host_data);
	modport host(input ready_strobe, word_xfer_n, intrq, pdiag_n, dasp_n, dev_data,
		output reset_n, stop, host_wstrobe, mode, pdiag_host_o, pdiag_host_oe, dasp_host_o, dasp_host_oe, host_data);
endinterface

// >>> design/ata_hs_pkg.sv
// shared constants for the ata handshake link
package ata_hs_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned CLK_MHZ = 100;
	// strobe half period in ns and in cycles
	localparam int unsigned STROBE_HALF_NS = 30;
	localparam int unsigned STROBE_HALF_CYC = (STROBE_HALF_NS * CLK_MHZ + 999) / 1000;
	// free slots kept for host words still in flight when write-ready drops
	localparam int unsigned WR_SLACK = 4;
	localparam logic [1:0] MODE_PIO = 2'h0;
	localparam logic [1:0] MODE_UDMA_WR = 2'h1;
	localparam logic [1:0] MODE_UDMA_RD = 2'h2;
	localparam logic [1:0] MODE_IDLE = 2'h3;
endpackage

// >>> dv/ata_device_handshake_signals_tb_top.sv
// self-checking bench joining target and host ends
`timescale 1ns/1ps
module ata_device_handshake_signals_tb_top;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [15:0] d_rd_data = 16'h0, h_wr_data = 16'h0, d_wr_data, h_rd_data;
	logic d_rd_valid = 1'h0, d_wr_ready = 1'h0, word_acc = 1'h0, irq_req = 1'h0, diag_ok = 1'h0, act = 1'h0;
	logic dev_rst = 1'h0, stop = 1'h0, h_wr_valid = 1'h0;
	logic [1:0] mode = ata_hs_pkg::MODE_PIO;
	logic d_rd_ready, d_wr_valid, h_wr_ready, h_rd_valid, io_rdy, word_x, irq, diag_p, dev_act;
	logic d_peer_diag, d_peer_pres;
	int n_errors = 0;
	int checks_done = 0;
	int k;
	logic [15:0] rxq[$];
	logic [15:0] wq[$];
	always #5 clk = ~clk;
	ata_hs_if bus_if();
	ata_hs_dev #(.DEPTH(ata_hs_pkg::FIFO_DEPTH)) u_ata_hs_dev(.ref_clk_i(clk), .arst_n_i(rst_n), .bus(bus_if),
		.rd_data_i(d_rd_data), .rd_valid_i(d_rd_valid), .rd_ready_o(d_rd_ready), .wr_data_o(d_wr_data),
		.wr_valid_o(d_wr_valid), .wr_ready_i(d_wr_ready), .word_access_i(word_acc), .irq_req_i(irq_req),
		.diag_pass_i(diag_ok), .active_i(act), .peer_diag_o(d_peer_diag), .peer_present_o(d_peer_pres));
	ata_hs_host u_ata_hs_host(.ref_clk_i(clk), .arst_n_i(rst_n), .bus(bus_if), .mode_i(mode), .dev_reset_i(dev_rst),
		.stop_i(stop), .wr_data_i(h_wr_data), .wr_valid_i(h_wr_valid), .wr_ready_o(h_wr_ready),
		.rd_data_o(h_rd_data), .rd_valid_o(h_rd_valid), .io_ready_o(io_rdy), .word_xfer_o(word_x), .irq_o(irq),
		.diag_pass_o(diag_p), .dev_active_o(dev_act));
	ata_hs_checker u_ata_hs_checker(.ref_clk_i(clk), .arst_n_i(rst_n), .ready_strobe(bus_if.ready_strobe),
		.reset_n(bus_if.reset_n), .stop(bus_if.stop), .host_wstrobe(bus_if.host_wstrobe), .mode(bus_if.mode));
	always @(posedge clk) begin
		if (h_rd_valid === 1'h1) rxq.push_back(h_rd_data);
		if (d_wr_valid === 1'h1 && d_wr_ready === 1'h1) wq.push_back(d_wr_data);
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// host offers a word and holds it until taken
	task host_write(input logic [15:0] w);
		int i;
		h_wr_data <= w;
		h_wr_valid <= 1'h1;
		for (i = 0; i < 300; i++) begin
			@(posedge clk);
			if (h_wr_ready === 1'h1) break;
		end
		if (i == 300) begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	task wait_n(input int n, input bit rd);
		int i;
		for (i = 0; i < 300 && (rd ? rxq.size() : wq.size()) < n; i++) @(posedge clk);
		if (i == 300) begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	initial begin
		cyc(20000);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		cyc(5);
		rst_n <= 1'h1;
		cyc(6);
		for (int v = 1; v >= 0; v--) begin
			word_acc <= v[0];
			irq_req <= v[0];
			diag_ok <= v[0];
			act <= v[0];
			cyc(8);
			chk(io_rdy, 16'h1);
			chk(bus_if.word_xfer_n, v == 0);
			chk(word_x, v != 0);
			chk(bus_if.intrq, v != 0);
			chk(irq, v != 0);
			chk(diag_p, v != 0);
			chk(dev_act, v != 0);
			chk(d_peer_diag, v != 0);
			chk(d_peer_pres, v != 0);
		end
		dev_rst <= 1'h1;
		cyc(6);
		chk(bus_if.reset_n, 16'h0);
		dev_rst <= 1'h0;
		cyc(6);
		chk(bus_if.reset_n, 16'h1);
		mode <= ata_hs_pkg::MODE_UDMA_WR;
		cyc(8);
		chk(bus_if.ready_strobe, 16'h0);
		fork
			for (int j = 0; j < 12; j++) host_write(16'h5000 + 16'(j));
			begin
				cyc(60);
				chk(bus_if.ready_strobe, 16'h1);
				d_wr_ready <= 1'h1;
			end
		join
		h_wr_valid <= 1'h0;
		wait_n(12, 1'b0);
		for (int j = 0; j < 12; j++) chk(wq[j], 16'h5000 + 16'(j));
		mode <= ata_hs_pkg::MODE_IDLE;
		cyc(8);
		// fill the target's send buffer until it refuses
		for (k = 0; k < 20; k++) begin
			d_rd_data <= 16'ha000 + 16'(k);
			d_rd_valid <= 1'h1;
			@(posedge clk);
			if (d_rd_ready !== 1'h1) break;
		end
		d_rd_valid <= 1'h0;
		chk(16'(k), 16'(ata_hs_pkg::FIFO_DEPTH));
		mode <= ata_hs_pkg::MODE_UDMA_RD;
		wait_n(2, 1'b1);
		stop <= 1'h1;
		cyc(40);
		chk(rxq.size() < 8, 16'h1);
		mode <= ata_hs_pkg::MODE_IDLE;
		stop <= 1'h0;
		cyc(8);
		mode <= ata_hs_pkg::MODE_UDMA_RD;
		wait_n(8, 1'b1);
		cyc(10);
		chk(16'(rxq.size()), 16'h8);
		for (int j = 0; j < 8; j++) chk(rxq[j], 16'ha000 + 16'(j));
		tally_and_finish();
	end
endmodule

// >>> dv/ata_hs_checker.sv
// assertions on the wires between target and host
`timescale 1ns/1ps
module ata_hs_checker (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic ready_strobe,
	input wire logic reset_n,
	input wire logic stop,
	input wire logic host_wstrobe,
	input wire logic [1:0] mode
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	property p_pio_ready;
		(mode == ata_hs_pkg::MODE_PIO) [*6] |-> ready_strobe;
	endproperty
	a_pio_ready: assert property (p_pio_ready) else $error("ready low in pio");
	property p_rd_gap;
		(mode == ata_hs_pkg::MODE_UDMA_RD && $changed(ready_strobe))
			|=> (mode != ata_hs_pkg::MODE_UDMA_RD || $stable(ready_strobe)) [*2];
	endproperty
	a_rd_gap: assert property (p_rd_gap) else $error("strobe edges too close");
	property p_idle_quiet;
		(mode == ata_hs_pkg::MODE_IDLE) [*6] |-> $stable(ready_strobe);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("strobe moved while idle");
	property p_wr_pause;
		(mode == ata_hs_pkg::MODE_UDMA_WR && ready_strobe) [*8] |-> $stable(host_wstrobe);
	endproperty
	a_wr_pause: assert property (p_wr_pause) else $error("host sent while paused");
	property p_rd_stop;
		(stop && mode == ata_hs_pkg::MODE_UDMA_RD) [*5] |-> $stable(ready_strobe);
	endproperty
	a_rd_stop: assert property (p_rd_stop) else $error("strobe after stop");
	property p_wr_stop;
		stop [*4] |-> $stable(host_wstrobe);
	endproperty
	a_wr_stop: assert property (p_wr_stop) else $error("host strobe after stop");
	property p_wstrobe_mode;
		$changed(host_wstrobe) |-> (mode == ata_hs_pkg::MODE_UDMA_WR || $past(mode) == ata_hs_pkg::MODE_UDMA_WR);
	endproperty
	a_wstrobe_mode: assert property (p_wstrobe_mode) else $error("host strobe outside write");
	property p_reset_idle;
		(!reset_n) [*5] |-> ready_strobe;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("ready low in reset");
endmodule
